// *** rtcc_timekeeping_core.sv ***
// rtcc_timekeeping_core: oscillator monitor, hundredths generator, bcd calendar and buffered register port
`timescale 1ns/1ps
// Overview of operation
// - external 32.768 kHz clock on the crystal pin is used while external select is set, even with the start bit clear.
// - running flag sets by itself after 32 oscillator cycles are seen.
// - running flag clears itself when no oscillator cycle is seen beyond the stop timeout.
// - separate hundredths, seconds, minutes, hours, weekday, date, month, two-digit year registers.
// - months shorter than 31 days and leap years 2001 to 2099 handled automatically.
// - hours count in 12-hour or 24-hour format as the format bit selects.
// - weekday counts 1 to 7, advances at midnight, wraps to 1 with no carry.
// - every time and date field is kept and shown in bcd.
// - timekeeping keeps advancing while running from the backup supply.
// - a read starting at addresses 0x00 to 0x1F captures live counters into buffers.
// - in a burst read, buffers refresh whenever the address wraps 0x1F to 0x00.
// - day ends 23:59:59.99 to 00:00:00.00, or 11:59:59.99 PM to 12 AM; carries date, weekday.
// - date carries after 31, 30, or February 28 / 29 in leap years.
// - after December 31 the calendar goes to January 1 and the year increments.
// - year wraps 99 to 00 without further carry.
// - hundredths advance every 41 ticks of 4.096 kHz 24 times, then once after 40.
// - crystal oscillator runs only while the start bit is set.
// - format bit 1 selects 12-hour, 0 selects 24-hour; PM indicator 1 means afternoon.
module rtcc_timekeeping_core
  import rtcc_pkg::*;
#(
  parameter int unsigned OSF_LIMIT = OSF_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic crystal_input_pin,
  input wire logic wr_en,
  input wire logic rd_start,
  input wire logic rd_next,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic oscillator_running_flag,
  output logic osc_drive_en
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {4'(v[7:4] + 4'h1), 4'h0} : {v[7:4], 4'(v[3:0] + 4'h1)};
  endfunction

  // wraps from last to first, otherwise one bcd step up
  function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] last, input logic [7:0] first);
    return (v == last) ? first : bcd_inc(v);
  endfunction

  // two-digit year divisible by four; 00 counts as leap, right for 2000 and 2400
  function automatic logic is_leap(input logic [7:0] y);
    if (!y[4]) begin
      return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
    return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
  endfunction

  function automatic logic [7:0] month_last(input logic [4:0] m, input logic leap);
    if (m == 5'h02) begin
      return leap ? 8'h29 : 8'h28;
    end else if ((m == 5'h04) || (m == 5'h06) || (m == 5'h09) || (m == 5'h11)) begin
      return 8'h30;
    end
    return 8'h31;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser: [0] and [1] form the two-flop chain, [2] delays for edge detect

  logic [2:0] pin_sync_q, pin_sync_d;
  logic osc_edge;

  always_comb begin
    pin_sync_d = {pin_sync_q[1:0], crystal_input_pin};
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_sync_q <= 3'h0;
    end else if (ce) begin
      pin_sync_q <= pin_sync_d;
    end
  end

  assign osc_edge = pin_sync_q[1] & ~pin_sync_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // timekeeping state

  logic [7:0] hsec_q, hsec_d, sec_q, sec_d, min_q, min_d, hour_q, hour_d;
  logic [7:0] date_q, date_d, year_q, year_d, ctrl_q, ctrl_d;
  logic [4:0] mth_q, mth_d, phase_q, phase_d;
  logic [2:0] wkday_q, wkday_d, div_q, div_d;
  logic [5:0] edge_cnt_q, edge_cnt_d, tick_cnt_q, tick_cnt_d;
  logic [31:0] idle_cnt_q, idle_cnt_d;
  logic vbat_q, vbat_d, run_q, run_d, drive_q, drive_d;
  logic osc_en, edge_ok, tick, hstep, day_c, date_c, mth_c;
  logic [7:0] tmp;

  // the crystal amplifier is only driven in crystal mode; external mode takes the pin directly
  assign osc_en = ctrl_q[CTRL_EXT_BIT] | sec_q[SEC_START_BIT];
  assign edge_ok = osc_edge & osc_en;
  assign tick = edge_ok && (div_q == TICK_DIV_LAST);

  // running monitor, divider, hundredths pattern, bcd cascade and host writes
  always_comb begin
    drive_d = sec_q[SEC_START_BIT] & ~ctrl_q[CTRL_EXT_BIT];
    run_d = run_q;
    edge_cnt_d = edge_cnt_q;
    idle_cnt_d = idle_cnt_q;
    div_d = div_q;
    tick_cnt_d = tick_cnt_q;
    phase_d = phase_q;
    hstep = 1'b0;
    day_c = 1'b0;
    date_c = 1'b0;
    mth_c = 1'b0;
    tmp = 8'h00;
    hsec_d = hsec_q;
    sec_d = sec_q;
    min_d = min_q;
    hour_d = hour_q;
    wkday_d = wkday_q;
    date_d = date_q;
    mth_d = mth_q;
    year_d = year_q;
    ctrl_d = ctrl_q;
    vbat_d = vbat_q;
    // set and clear are never in the same cycle: set needs an edge, clear needs none
    if (edge_ok) begin
      idle_cnt_d = 32'h0;
      div_d = 3'(div_q + 3'h1);
      if (edge_cnt_q != 6'd32) begin
        edge_cnt_d = 6'(edge_cnt_q + 6'd1);
      end
      if (edge_cnt_q == RUN_EDGES_LAST) begin
        run_d = 1'b1;
      end
    end else if (idle_cnt_q == OSF_LIMIT) begin
      run_d = 1'b0;
      edge_cnt_d = 6'd0;
    end else begin
      idle_cnt_d = 32'(idle_cnt_q + 32'h1);
    end
    // 24 periods of 41 ticks then one of 40 give exactly 250 ms per 25 steps
    if (tick) begin
      if (tick_cnt_q == ((phase_q == HSEC_PHASE_LAST) ? HSEC_SHORT_LAST : HSEC_LONG_LAST)) begin
        tick_cnt_d = 6'd0;
        phase_d = (phase_q == HSEC_PHASE_LAST) ? 5'd0 : 5'(phase_q + 5'd1);
        hstep = 1'b1;
      end else begin
        tick_cnt_d = 6'(tick_cnt_q + 6'd1);
      end
    end
    // bcd cascade, runs from the same timebase on main or backup supply
    if (hstep) begin
      hsec_d = bcd_step(hsec_q, 8'h99, 8'h00);
      if (hsec_q == 8'h99) begin
        tmp = bcd_step({1'b0, sec_q[6:0]}, 8'h59, 8'h00);
        sec_d = {sec_q[SEC_START_BIT], tmp[6:0]};
        if (sec_q[6:0] == 7'h59) begin
          min_d = bcd_step(min_q, 8'h59, 8'h00);
          if (min_q == 8'h59) begin
            if (hour_q[HOUR_FMT_BIT]) begin
              tmp = {3'h0, hour_q[4:0]};
              if (tmp == 8'h12) begin
                hour_d[4:0] = 5'h01;
              end else if (tmp == 8'h11) begin
                hour_d[4:0] = 5'h12;
                hour_d[HOUR_PM_BIT] = ~hour_q[HOUR_PM_BIT];
                day_c = hour_q[HOUR_PM_BIT];
              end else begin
                tmp = bcd_inc(tmp);
                hour_d[4:0] = tmp[4:0];
              end
            end else begin
              tmp = bcd_step({2'h0, hour_q[5:0]}, 8'h23, 8'h00);
              hour_d[5:0] = tmp[5:0];
              day_c = (hour_q[5:0] == 6'h23);
            end
          end
        end
      end
    end
    if (day_c) begin
      wkday_d = (wkday_q == 3'h7) ? 3'h1 : 3'(wkday_q + 3'h1);
      date_c = (date_q == month_last(mth_q, is_leap(year_q)));
      date_d = bcd_step(date_q, month_last(mth_q, is_leap(year_q)), 8'h01);
    end
    if (date_c) begin
      mth_c = (mth_q == 5'h12);
      tmp = bcd_step({3'h0, mth_q}, 8'h12, 8'h01);
      mth_d = tmp[4:0];
    end
    if (mth_c) begin
      year_d = bcd_step(year_q, 8'h99, 8'h00);
    end
    // a host write wins over a same-cycle count; values are trusted to be valid bcd
    if (wr_en) begin
      if (addr == ADDR_HSEC) begin
        hsec_d = wdata;
      end else if (addr == ADDR_SEC) begin
        sec_d = wdata;
      end else if (addr == ADDR_MIN) begin
        min_d = {1'b0, wdata[6:0]};
      end else if (addr == ADDR_HOUR) begin
        hour_d = wdata;
      end else if (addr == ADDR_WKDAY) begin
        vbat_d = wdata[WKDAY_VBAT_BIT];
        wkday_d = wdata[2:0];
      end else if (addr == ADDR_DATE) begin
        date_d = {2'h0, wdata[5:0]};
      end else if (addr == ADDR_MTH) begin
        mth_d = wdata[4:0];
      end else if (addr == ADDR_YEAR) begin
        year_d = wdata;
      end else if (addr == ADDR_CTRL) begin
        ctrl_d = wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_q <= 1'b0;
      drive_q <= 1'b0;
      edge_cnt_q <= 6'd0;
      idle_cnt_q <= 32'h0;
      div_q <= 3'h0;
      tick_cnt_q <= 6'd0;
      phase_q <= 5'd0;
      hsec_q <= RST_HSEC;
      sec_q <= RST_SEC;
      min_q <= RST_MIN;
      hour_q <= RST_HOUR;
      wkday_q <= RST_WKDAY;
      vbat_q <= 1'b0;
      date_q <= RST_DATE;
      mth_q <= RST_MTH;
      year_q <= RST_YEAR;
      ctrl_q <= RST_CTRL;
    end else if (ce) begin
      run_q <= run_d;
      drive_q <= drive_d;
      edge_cnt_q <= edge_cnt_d;
      idle_cnt_q <= idle_cnt_d;
      div_q <= div_d;
      tick_cnt_q <= tick_cnt_d;
      phase_q <= phase_d;
      hsec_q <= hsec_d;
      sec_q <= sec_d;
      min_q <= min_d;
      hour_q <= hour_d;
      wkday_q <= wkday_d;
      vbat_q <= vbat_d;
      date_q <= date_d;
      mth_q <= mth_d;
      year_q <= year_d;
      ctrl_q <= ctrl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read buffers: a snapshot keeps a multi-byte read free of mid-read rollover

  logic [7:0] live [0:NUM_TK_REGS-1];
  logic [7:0] snap_q [0:NUM_TK_REGS-1];
  logic [7:0] snap_d [0:NUM_TK_REGS-1];
  logic [7:0] rd_ptr_q, rd_ptr_d, rdata_q, rdata_d;
  rtcc_rd_e rd_st_q, rd_st_d;

  always_comb begin
    live[0] = hsec_q;
    live[1] = sec_q;
    live[2] = min_q;
    live[3] = hour_q;
    live[4] = {2'h0, run_q, 1'b0, vbat_q, wkday_q};
    live[5] = date_q;
    live[6] = {2'h0, is_leap(year_q), mth_q};
    live[7] = year_q;
    live[8] = ctrl_q;
  end

  // registers 0x09 to 0x1F are outside this core and read as zero
  always_comb begin
    snap_d = snap_q;
    rd_ptr_d = rd_ptr_q;
    rd_st_d = rd_st_q;
    rdata_d = rdata_q;
    if (rd_start) begin
      if (addr <= ADDR_CLK_LAST) begin
        snap_d = live;
        rd_ptr_d = addr;
        rd_st_d = RD_BURST;
        rdata_d = (addr <= ADDR_CTRL) ? live[addr[3:0]] : 8'h00;
      end else begin
        rd_st_d = RD_IDLE;
        rdata_d = 8'h00;
      end
    end else if (rd_next && (rd_st_q == RD_BURST)) begin
      case (rd_ptr_q)
        ADDR_CLK_LAST: begin
          snap_d = live;
          rd_ptr_d = 8'h00;
          rdata_d = live[0];
        end
        default: begin
          rd_ptr_d = 8'(rd_ptr_q + 8'h01);
          rdata_d = (rd_ptr_q < ADDR_CTRL) ? snap_q[4'(rd_ptr_q[3:0] + 4'h1)] : 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_TK_REGS; i++) begin
        snap_q[i] <= 8'h00;
      end
      rd_ptr_q <= 8'h00;
      rd_st_q <= RD_IDLE;
      rdata_q <= 8'h00;
    end else if (ce) begin
      snap_q <= snap_d;
      rd_ptr_q <= rd_ptr_d;
      rd_st_q <= rd_st_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;
  assign oscillator_running_flag = run_q;
  assign osc_drive_en = drive_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_run_set_count: assert property ($rose(run_q) |-> $past(edge_cnt_q) == RUN_EDGES_LAST)
    else $error("running flag set before 32 edges");
  a_run_clear_idle: assert property ($fell(run_q) |-> $past(idle_cnt_q) == OSF_LIMIT)
    else $error("running flag cleared before timeout");
  a_hold_disabled: assert property ((ce && !osc_en) |=> (div_q == $past(div_q)) && (tick_cnt_q == $past(tick_cnt_q)))
    else $error("timebase advanced while disabled");
  a_short_period: assert property ((ce && tick && phase_q == 5'd24 && tick_cnt_q == 6'd39) |=> phase_q == 5'd0)
    else $error("short hundredth period not 40 ticks");
  a_long_period: assert property ((ce && tick && phase_q != 5'd24 && tick_cnt_q == 6'd39) |=> tick_cnt_q == 6'd40)
    else $error("long hundredth period cut short");
  a_weekday_wrap: assert property ((ce && !wr_en && day_c && wkday_q == 3'h7) |=> wkday_q == 3'h1)
    else $error("weekday did not wrap to 1");
  a_year_wrap: assert property ((ce && !wr_en && mth_c && year_q == 8'h99) |=> year_q == 8'h00)
    else $error("year did not wrap to 00");
  a_feb_end: assert property ((ce && !wr_en && day_c && mth_q == 5'h02 && date_q == 8'h28 && !is_leap(year_q))
    |=> date_q == 8'h01 && mth_q == 5'h03)
    else $error("february end wrong");
  a_burst_refresh: assert property ((ce && rd_next && !rd_start && rd_st_q == RD_BURST && rd_ptr_q == ADDR_CLK_LAST)
    |=> rd_ptr_q == 8'h00 && snap_q[0] == $past(hsec_q))
    else $error("buffers not refreshed on wrap");

endmodule // rtcc_timekeeping_core

// *** rtcc_pkg.sv ***
// rtcc_pkg: register map, field positions, reset values and timing constants of the timekeeping core
package rtcc_pkg;

  // register addresses
  localparam logic [7:0] ADDR_HSEC = 8'h00;
  localparam logic [7:0] ADDR_SEC = 8'h01;
  localparam logic [7:0] ADDR_MIN = 8'h02;
  localparam logic [7:0] ADDR_HOUR = 8'h03;
  localparam logic [7:0] ADDR_WKDAY = 8'h04;
  localparam logic [7:0] ADDR_DATE = 8'h05;
  localparam logic [7:0] ADDR_MTH = 8'h06;
  localparam logic [7:0] ADDR_YEAR = 8'h07;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_CLK_LAST = 8'h1F;
  localparam int unsigned NUM_TK_REGS = 9;

  // field positions
  localparam int unsigned SEC_START_BIT = 7;
  localparam int unsigned HOUR_FMT_BIT = 6;
  localparam int unsigned HOUR_PM_BIT = 5;
  localparam int unsigned WKDAY_VBAT_BIT = 3;
  localparam int unsigned CTRL_EXT_BIT = 3;

  // values after reset
  localparam logic [7:0] RST_HSEC = 8'h00;
  localparam logic [7:0] RST_SEC = 8'h00;
  localparam logic [7:0] RST_MIN = 8'h00;
  localparam logic [7:0] RST_HOUR = 8'h00;
  localparam logic [2:0] RST_WKDAY = 3'h1;
  localparam logic [7:0] RST_DATE = 8'h01;
  localparam logic [4:0] RST_MTH = 5'h01;
  localparam logic [7:0] RST_YEAR = 8'h01;
  localparam logic [7:0] RST_CTRL = 8'h00;

  // oscillator and hundredths timing
  localparam logic [5:0] RUN_EDGES_LAST = 6'd31;
  localparam logic [2:0] TICK_DIV_LAST = 3'h7;
  localparam logic [5:0] HSEC_LONG_LAST = 6'd40;
  localparam logic [5:0] HSEC_SHORT_LAST = 6'd39;
  localparam logic [4:0] HSEC_PHASE_LAST = 5'd24;

  // oscillator-stop timeout, least time so rounded up
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned OSF_TIMEOUT_US = 1000;
  localparam int unsigned OSF_CYCLES = (OSF_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // read buffer state
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_BURST = 2'b10
  } rtcc_rd_e;

endpackage

// *** rtcc_host_model.sv ***
// rtcc_host_model: host controller model issuing writes, reads and bursts on the register port
`timescale 1ns/1ps
module rtcc_host_model
  import rtcc_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rdata,
  input wire logic oscillator_running_flag,
  output logic wr_en,
  output logic rd_start,
  output logic rd_next,
  output logic [7:0] addr,
  output logic [7:0] wdata
);
  ////////////////////////////////////////
  // port idle from time zero
  initial begin
    wr_en = 1'b0;
    rd_start = 1'b0;
    rd_next = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end

  ////////////////////////////////////////
  // one request from a falling edge, held across the taking edge; address and data are then
  // inverted so the core cannot lean on stale values; the leading wait lets a rising edge pass
  // between two requests, so a strobe is never lowered and raised in one time step
  task automatic req(input logic w, input logic s, input logic n, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_en = w;
    rd_start = s;
    rd_next = n;
    addr = a;
    wdata = d;
    @(posedge clk);
    @(negedge clk);
    wr_en = 1'b0;
    rd_start = 1'b0;
    rd_next = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req(1'b1, 1'b0, 1'b0, a, d);
  endtask

  // data is taken one cycle late; it holds, so this is safe for either answer edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    req(1'b0, 1'b1, 1'b0, a, 8'h00);
    @(negedge clk);
    d = rdata;
  endtask

  task automatic nxt(output logic [7:0] d);
    req(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
    @(negedge clk);
    d = rdata;
  endtask

  // the whole time and date in one transaction, so one snapshot serves all bytes
  task automatic read_all(output logic [7:0] r [8]);
    rd(ADDR_HSEC, r[0]);
    for (int i = 1; i < 8; i++) nxt(r[i]);
  endtask

  // stop the timebase and wait for the stop to show before loading, so no carry lands mid-load
  // ok reports whether the running flag really cleared before the wait limit ran out
  task automatic set_time(input logic [7:0] v [8], output logic ok);
    int n;
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_SEC, 8'h00);
    n = 0;
    while (oscillator_running_flag !== 1'b0 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    ok = (oscillator_running_flag === 1'b0);
    for (int i = 0; i < 8; i++) wr(8'(i), v[i]);
    wr(ADDR_CTRL, 8'h08);
  endtask
endmodule // rtcc_host_model

// *** testbench.sv ***
// testbench: self-checking bench for the timekeeping core behind a host model
`timescale 1ns/1ps
module testbench
  import rtcc_pkg::*;
;
  localparam int unsigned LIM = 20;
  logic clk;
  logic nrst;
  logic ce;
  logic pin;
  logic wr_en;
  logic rd_start;
  logic rd_next;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic run;
  logic drv;
  logic [7:0] r [8];
  logic [7:0] e [8];
  logic [7:0] b;
  int n_errors;
  int checks_done;
  int seed;

  ////////////////////////////////////////
  // core with a short stop timeout, host model on its register port
  rtcc_timekeeping_core #(.OSF_LIMIT(LIM)) rtcc_timekeeping_core_i (.clk(clk), .nrst(nrst), .ce(ce),
    .crystal_input_pin(pin), .wr_en(wr_en), .rd_start(rd_start), .rd_next(rd_next), .addr(addr),
    .wdata(wdata), .rdata(rdata), .oscillator_running_flag(run), .osc_drive_en(drv));
  rtcc_host_model rtcc_host_model_i (.clk(clk), .rdata(rdata), .oscillator_running_flag(run),
    .wr_en(wr_en), .rd_start(rd_start), .rd_next(rd_next), .addr(addr), .wdata(wdata));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic do_reset;
    nrst = 1'b0;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
  endtask

  // pin edges four clocks apart, then time for the synchroniser to settle
  task automatic edges(input int n);
    repeat (n) begin
      pin = 1'b1;
      repeat (2) @(negedge clk);
      pin = 1'b0;
      repeat (2) @(negedge clk);
    end
    repeat (6) @(negedge clk);
  endtask

  task automatic hs(input logic [7:0] exp);
    rtcc_host_model_i.rd(ADDR_HSEC, b);
    check(b, exp);
  endtask

  function automatic logic [7:0] bcd(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction

  function automatic int last_day(input int m, input int y);
    if (m == 2) return (y % 4 == 0) ? 29 : 28;
    if (m == 4 || m == 6 || m == 9 || m == 11) return 30;
    return 31;
  endfunction

  // load one hundredth before midnight, run one hundredth, check snapshot, wrap refresh and new date
  task automatic roll(input int m, input int d, input int y, input int wk, input logic h12);
    logic [7:0] v [8];
    logic ok;
    int nd;
    int nm;
    int ny;
    nd = d + 1;
    nm = m;
    ny = y;
    if (d == last_day(m, y)) begin
      nd = 1;
      nm = m % 12 + 1;
      ny = (m == 12) ? (y + 1) % 100 : y;
    end
    // 12-hour runs also enable the backup supply, so counting on it is checked too
    v = '{8'h99, 8'h59, 8'h59, h12 ? 8'h71 : 8'h23, bcd(wk) | (h12 ? 8'h08 : 8'h00), bcd(d), bcd(m), bcd(y)};
    // pin is quiet by the time these are read, so the running bit has dropped
    e = '{8'h00, 8'h00, 8'h00, h12 ? 8'h52 : 8'h00, bcd(wk % 7 + 1) | (h12 ? 8'h08 : 8'h00), bcd(nd),
      bcd(nm) | (ny % 4 == 0 ? 8'h20 : 8'h00), bcd(ny)};
    do_reset;
    rtcc_host_model_i.set_time(v, ok);
    check({7'h00, ok}, 8'h01);
    rtcc_host_model_i.rd(ADDR_HSEC, b);
    check(b, 8'h99);
    edges(41 * 8);
    rtcc_host_model_i.nxt(b);
    check(b, 8'h59);
    repeat (31) rtcc_host_model_i.nxt(b);
    check(b, 8'h00);
    // a zero byte cannot tell a refresh from a plain miss; the weekday byte of the new snapshot can
    repeat (4) rtcc_host_model_i.nxt(b);
    check(b, e[4]);
    rtcc_host_model_i.read_all(r);
    for (int i = 0; i < 8; i++) check(r[i], e[i]);
  endtask

  ////////////////////////////////////////
  // main sequence
  initial begin
    int m;
    int y;
    n_errors = 0;
    checks_done = 0;
    seed = 32'hA38435F8;
    ce = 1'b1;
    pin = 1'b0;
    do_reset;
    edges(400);
    rtcc_host_model_i.read_all(r);
    e = '{RST_HSEC, RST_SEC, RST_MIN, RST_HOUR, {5'h00, RST_WKDAY}, RST_DATE, {3'h0, RST_MTH}, RST_YEAR};
    for (int i = 0; i < 8; i++) check(r[i], e[i]);
    rtcc_host_model_i.rd(ADDR_CTRL, b);
    check(b, RST_CTRL);
    rtcc_host_model_i.rd(8'h09, b);
    check(b, 8'h00);
    rtcc_host_model_i.wr(8'h20, 8'h55);
    rtcc_host_model_i.wr(ADDR_WKDAY, 8'h3F);
    rtcc_host_model_i.rd(ADDR_WKDAY, b);
    check(b, 8'h0F);
    rtcc_host_model_i.wr(ADDR_SEC, 8'h80);
    repeat (2) @(negedge clk);
    check({7'h00, drv}, 8'h01);
    rtcc_host_model_i.wr(ADDR_CTRL, 8'h08);
    repeat (2) @(negedge clk);
    check({7'h00, drv}, 8'h00);
    edges(31);
    check({7'h00, run}, 8'h00);
    edges(1);
    check({7'h00, run}, 8'h01);
    rtcc_host_model_i.wr(ADDR_SEC, 8'h00);
    rtcc_host_model_i.wr(ADDR_CTRL, 8'h00);
    repeat (LIM + 10) @(negedge clk);
    check({7'h00, run}, 8'h00);
    // hundredths cadence: 24 steps of 41 ticks, then one of 40
    do_reset;
    rtcc_host_model_i.wr(ADDR_CTRL, 8'h08);
    edges(41 * 8 * 24 - 1);
    hs(8'h23);
    edges(1);
    hs(8'h24);
    edges(319);
    hs(8'h24);
    edges(1);
    hs(8'h25);
    roll(12, 31, 99, 7, 1'b0);
    roll(2, 28, 24, 3, 1'b1);
    roll(2, 28, 23, 5, 1'b0);
    roll(4, 30, 10, 1, 1'b1);
    roll(1, 15, 5, 6, 1'b0);
    repeat (6) begin
      m = 1 + $unsigned($random(seed)) % 12;
      y = $unsigned($random(seed)) % 100;
      roll(m, last_day(m, y) - $unsigned($random(seed)) % 2, y, 1 + $unsigned($random(seed)) % 7, 1'($random(seed)));
    end
    end_sim;
  end

  // watchdog well beyond the expected run of about 51000 cycles
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    end_sim;
  end
endmodule // testbench
